// ### verilog/sbi_ctrl.sv
// serial bus control and mode select with apb register access
//
// Added by the designer: register access over APB and the address map.
`include "sbi_cfg.svh"
`timescale 1ns/1ps
module sbi_ctrl
    import sbi_pkg::*;
(
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // open-drain bus lines
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // interrupt
    output logic serial_bus_interrupt
);

    // register state
    logic ctlr_sel_reg;
    logic xmit_sel_reg;
    mode_type mode_reg;
    logic [1:0] gear_reg;
    logic [`SBI_EVT_W-1:0] evt_reg;
    logic [`SBI_EVT_W-1:0] mask_reg;
    logic soft_rst_arm_reg;
    logic soft_rst_reg;

    // interface state
    logic int_pending_reg;
    logic bus_busy_reg;
    logic lost_reg;
    logic lrb_reg;
    logic [3:0] bit_cnt_reg;
    gen_state_type gen_state_reg;
    gen_state_type gen_state_next;
    logic scl_prev_reg;
    logic sda_prev_reg;

    // bus decode
    logic setup_rd;
    logic wr_en;
    logic hit_ctrl;
    logic hit_evt;
    logic hit_mask;
    logic hit_gear;
    logic mapped;
    logic wr_ctrl;
    logic [7:0] status;
    logic [31:0] rd_data;

    // line sensing
    logic [1:0] lines;
    logic scl_s;
    logic sda_s;
    logic in_i2c;
    logic in_sio;
    logic scl_rise;
    logic start_seen;
    logic stop_seen;
    logic unit_done;
    logic gen_req;
    logic gen_refused;
    logic tick;
    logic [`SBI_EVT_W-1:0] evt_set;

    sbi_sync #(
        .WIDTH(2)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({sda_i, scl_i}),
        .sync_out(lines)
    );

    sbi_base_clock u_base (
        .pclk(pclk),
        .presetn(presetn),
        .gear(gear_reg),
        .tick(tick)
    );

    assign scl_s = lines[0];
    assign sda_s = lines[1];

    // reserved mode 11 behaves as port mode: nothing drives, nothing counts
    assign in_i2c = (mode_reg == mode_i2c);
    assign in_sio = (mode_reg == mode_sio);

    // apb slave
    assign hit_ctrl = (paddr == `SBI_CTRL_OFS);
    assign hit_evt = (paddr == `SBI_EVT_OFS);
    assign hit_mask = (paddr == `SBI_MASK_OFS);
    assign hit_gear = (paddr == `SBI_GEAR_OFS);
    assign mapped = hit_ctrl | hit_evt | hit_mask | hit_gear;
    assign setup_rd = psel & penable & ~pready;
    assign wr_en = psel & penable & pready & pwrite & mapped;
    assign wr_ctrl = wr_en & hit_ctrl;

    // al, aas and ado report only lost arbitration here; the rest read 0
    assign status = {ctlr_sel_reg, xmit_sel_reg, bus_busy_reg,
                     ~int_pending_reg,
                     lost_reg, 2'h0, lrb_reg};

    always_comb begin
        rd_data = 32'h0;
        if (hit_ctrl) begin
            // reads land on the status register, upper bits zero
            rd_data = {24'h0, status};
        end else if (hit_evt) begin
            rd_data = {28'h0, evt_reg};
        end else if (hit_mask) begin
            rd_data = {28'h0, mask_reg};
        end else if (hit_gear) begin
            rd_data = {30'h0, gear_reg};
        end
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup_rd;
            pslverr <= setup_rd & ~mapped;
            if (setup_rd & ~pwrite) begin
                prdata <= rd_data;
            end
        end
    end

    // control register
    // only the low byte is decoded; pwdata[31:8] never reaches any state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctlr_sel_reg <= 1'b0;
            xmit_sel_reg <= 1'b0;
            mode_reg <= mode_port;
        end else if (wr_ctrl) begin
            ctlr_sel_reg <= pwdata[`SBI_CTLR_BIT];
            xmit_sel_reg <= pwdata[`SBI_XMIT_BIT];
            // mode changes take effect at once; software has already
            // checked that the bus is idle and the lines are high
            mode_reg <= mode_type'(pwdata[`SBI_MODE_LSB +: 2]);
        end
    end

    // two-step software reset: arm on 10, fire on the very next write of 01
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_rst_arm_reg <= 1'b0;
            soft_rst_reg <= 1'b0;
        end else begin
            soft_rst_reg <= 1'b0;
            if (wr_ctrl) begin
                soft_rst_arm_reg <=
                    (pwdata[`SBI_SOFT_RST_LSB +: 2] == `SBI_SOFT_RST_ARM);
                soft_rst_reg <= soft_rst_arm_reg &
                    (pwdata[`SBI_SOFT_RST_LSB +: 2] == `SBI_SOFT_RST_FIRE);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gear_reg <= `SBI_GEAR_RST;
        end else if (wr_en & hit_gear) begin
            gear_reg <= pwdata[1:0];
        end
    end

    // line monitor
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_prev_reg;
    assign start_seen = in_i2c & scl_prev_reg & scl_s
                        & sda_prev_reg & ~sda_s;
    assign stop_seen = in_i2c & scl_prev_reg & scl_s
                       & ~sda_prev_reg & sda_s;
    assign unit_done = scl_rise & (in_sio | (in_i2c & bus_busy_reg))
                       & (bit_cnt_reg ==
                          (in_i2c ? `SBI_I2C_LAST : `SBI_SIO_LAST));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_busy_reg <= 1'b0;
        end else if (soft_rst_reg | ~in_i2c) begin
            bus_busy_reg <= 1'b0;
        end else if (start_seen) begin
            bus_busy_reg <= 1'b1;
        end else if (stop_seen) begin
            bus_busy_reg <= 1'b0;
        end
    end

    // a start restarts the count so a repeated start realigns the byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_reg <= 4'h0;
        end else if (soft_rst_reg | start_seen | ~(in_i2c | in_sio)) begin
            bit_cnt_reg <= 4'h0;
        end else if (unit_done) begin
            bit_cnt_reg <= 4'h0;
        end else if (scl_rise & (in_sio | bus_busy_reg)) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lrb_reg <= 1'b0;
        end else if (soft_rst_reg) begin
            lrb_reg <= 1'b0;
        end else if (scl_rise & (in_sio | in_i2c)) begin
            lrb_reg <= sda_s;
        end
    end

    // pending request: a unit finishing in the clear cycle still sets it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_pending_reg <= 1'b0;
        end else if (unit_done) begin
            int_pending_reg <= 1'b1;
        end else if (soft_rst_reg) begin
            int_pending_reg <= 1'b0;
        end else if (wr_ctrl & pwdata[`SBI_PIN_BIT]) begin
            int_pending_reg <= 1'b0;
        end
    end

    // start / stop generator
    // a start while another controller holds the bus is refused as lost
    assign gen_req = wr_ctrl & pwdata[`SBI_GEN_BIT] & pwdata[`SBI_CTLR_BIT]
                     & in_i2c & (gen_state_reg == gen_idle);
    assign gen_refused = gen_req & bus_busy_reg;

    always_comb begin
        gen_state_next = gen_state_reg;
        unique case (gen_state_reg)
            gen_idle: begin
                if (gen_req & ~bus_busy_reg) begin
                    gen_state_next = gen_start;
                end
            end
            gen_start: begin
                if (tick) begin
                    gen_state_next = gen_held;
                end
            end
            gen_held: begin
                if (wr_ctrl & ~pwdata[`SBI_GEN_BIT]) begin
                    gen_state_next = gen_stop;
                end
            end
            gen_stop: begin
                if (tick) begin
                    gen_state_next = gen_idle;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_state_reg <= gen_idle;
        end else if (soft_rst_reg | ~in_i2c) begin
            gen_state_reg <= gen_idle;
        end else begin
            gen_state_reg <= gen_state_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lost_reg <= 1'b0;
        end else if (gen_refused) begin
            lost_reg <= 1'b1;
        end else if (soft_rst_reg | gen_req) begin
            lost_reg <= 1'b0;
        end
    end

    // outputs only ever pull low; port mode releases both lines
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            sda_oe <= in_i2c & (gen_state_next != gen_idle)
                      & ~soft_rst_reg;
            scl_oe <= in_i2c & (gen_state_next == gen_held)
                      & ~soft_rst_reg;
        end
    end

    // interrupt
    always_comb begin
        evt_set = '0;
        evt_set[`SBI_EVT_BYTE] = unit_done;
        evt_set[`SBI_EVT_START] = start_seen;
        evt_set[`SBI_EVT_STOP] = stop_seen;
        evt_set[`SBI_EVT_LOST] = gen_refused;
    end

    // write one to clear; a new event in the same cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_reg <= '0;
        end else if (wr_en & hit_evt) begin
            evt_reg <= (evt_reg & ~pwdata[`SBI_EVT_W-1:0]) | evt_set;
        end else begin
            evt_reg <= evt_reg | evt_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= `SBI_MASK_RST;
        end else if (wr_en & hit_mask) begin
            mask_reg <= pwdata[`SBI_EVT_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_bus_interrupt <= 1'b0;
        end else begin
            serial_bus_interrupt <= |(evt_reg & mask_reg);
        end
    end

endmodule

// ### verilog/sbi_cfg.svh
// register map, field positions, reset values and timing for the serial bus
`ifndef SBI_CFG_SVH
`define SBI_CFG_SVH

// byte offsets on the apb
`define SBI_CTRL_OFS 12'h000
`define SBI_EVT_OFS 12'h004
`define SBI_MASK_OFS 12'h008
`define SBI_GEAR_OFS 12'h00c

// control / status field positions
`define SBI_SOFT_RST_LSB 0
`define SBI_MODE_LSB 2
`define SBI_PIN_BIT 4
`define SBI_GEN_BIT 5
`define SBI_XMIT_BIT 6
`define SBI_CTLR_BIT 7
`define SBI_AL_BIT 3
`define SBI_LRB_BIT 0

// soft reset patterns
`define SBI_SOFT_RST_ARM 2'h2
`define SBI_SOFT_RST_FIRE 2'h1

// event bits
`define SBI_EVT_BYTE 0
`define SBI_EVT_START 1
`define SBI_EVT_STOP 2
`define SBI_EVT_LOST 3
`define SBI_EVT_W 4

// reset values
`define SBI_MODE_RST 2'h0
`define SBI_GEAR_RST 2'h0
`define SBI_MASK_RST 4'h0

// base clock: divide by 2^(shift+gear)
`define SBI_BASE_SHIFT 2
`define SBI_DIV_W 5

// scl rising edges per unit: 8 data bits, plus acknowledge in i2c mode
`define SBI_SIO_LAST 4'h7
`define SBI_I2C_LAST 4'h8

`endif

// ### verilog/sbi_pkg.sv
// types shared by the serial bus control block
package sbi_pkg;

    typedef enum logic [1:0] {
        mode_port = 2'h0,
        mode_sio = 2'h1,
        mode_i2c = 2'h2,
        mode_rsvd = 2'h3
    } mode_type;

    // gray sequence: idle -> start -> held -> stop -> idle
    typedef enum logic [1:0] {
        gen_idle = 2'h0,
        gen_start = 2'h1,
        gen_held = 2'h3,
        gen_stop = 2'h2
    } gen_state_type;

endpackage

// ### verilog/sbi_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sbi_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // idle bus lines are high, so start from ones
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '1;
            sync_out <= '1;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

// ### verilog/sbi_base_clock.sv
// base clock tick generator selected by the clock gear
`include "sbi_cfg.svh"
`timescale 1ns/1ps
module sbi_base_clock (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // gear select
    input wire logic [1:0] gear,
    // one pulse per base clock period
    output logic tick
);

    logic [`SBI_DIV_W-1:0] cnt_reg;
    logic [`SBI_DIV_W-1:0] last;

    // divisor 4, 8, 16 or 32 system clocks
    assign last = `SBI_DIV_W'((1 << (`SBI_BASE_SHIFT + gear)) - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end else if (cnt_reg >= last) begin
            // a gear change applies at once; a count already past the new last wraps here
            cnt_reg <= '0;
            tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + `SBI_DIV_W'(1);
            tick <= 1'b0;
        end
    end

endmodule

// ### verif/sbi_ctrl_checker.sv
// port assertions for the serial bus control block
`timescale 1ns/1ps
module sbi_ctrl_checker (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // bus lines
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_o,
    input wire logic sda_oe,
    // interrupt
    input wire logic serial_bus_interrupt
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic ctrl_wr;
    logic [1:0] mode_reg;
    logic [1:0] quiet_reg;
    assign ctrl_wr = psel && penable && pready && pwrite && paddr == 12'h000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= 2'h0;
        end else if (ctrl_wr) begin
            mode_reg <= pwdata[3:2];
        end
    end
    // outputs may lag a mode write, so only judge after three quiet cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quiet_reg <= 2'h3;
        end else if (ctrl_wr || mode_reg == 2'h2) begin
            quiet_reg <= 2'h0;
        end else if (quiet_reg != 2'h3) begin
            quiet_reg <= quiet_reg + 2'h1;
        end
    end
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held over one cycle");
    a_one_wait: assert property (psel && penable && !pready
        && !$past(penable) |=> pready)
        else $error("pready not in second access cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_unmapped_err: assert property (pready && paddr[1:0] == 2'h0
        |-> pslverr == (paddr > 12'h00c))
        else $error("pslverr does not match address map");
    a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 0)
        else $error("refused read returned data");
    a_ctrl_readback: assert property (
        pready && !pwrite && paddr == 12'h000
        |-> prdata[31:8] == 24'h0 && prdata[2:1] == 2'h0)
        else $error("status read has stray bits");
    a_rdata_hold: assert property (!(pready && !pwrite) |-> $stable(prdata))
        else $error("prdata changed outside a read");
    a_quiet_modes: assert property (
        quiet_reg == 2'h3 |-> !scl_oe && !sda_oe)
        else $error("lines driven outside i2c mode");
    a_mask_off: assert property (pready && pwrite && paddr == 12'h008
        && pwdata[3:0] == 4'h0 |-> ##2 !serial_bus_interrupt)
        else $error("interrupt with all events masked");
    a_drive_low: assert property (!scl_o && !sda_o)
        else $error("line drive value not low");
endmodule
bind sbi_ctrl sbi_ctrl_checker sbi_ctrl_checker_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o),
    .sda_oe(sda_oe), .serial_bus_interrupt(serial_bus_interrupt));

// ### verif/sbi_peer.sv
// far-side bus device model: open-drain clock and data, 64 ns link clock
`timescale 1ns/1ps
module sbi_peer (
    // pull-low enables
    output logic scl_oe,
    output logic sda_oe
);
    // released lines float high on the pull-ups
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    task automatic start_cond();
        sda_oe = 1'b1;
        #32 scl_oe = 1'b1;
    endtask
    // data moves 8 ns after clock falls so it is never seen as start/stop
    task automatic clock_bit(input logic b);
        scl_oe = 1'b1;
        #8 sda_oe = ~b;
        #24 scl_oe = 1'b0;
        #32;
    endtask
    task automatic stop_cond();
        scl_oe = 1'b1;
        #8 sda_oe = 1'b1;
        #24 scl_oe = 1'b0;
        #32 sda_oe = 1'b0;
    endtask
endmodule

// ### verif/tb_top.sv
// self-checking bench for the serial bus control block
`timescale 1ns/1ps
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, irq;
    logic p_scl_oe, p_sda_oe, scl, sda, err;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    int t0;
    int span;
    always #2 pclk = ~pclk;
    assign scl = (scl_oe ? scl_o : 1'b1) & ~p_scl_oe;
    assign sda = (sda_oe ? sda_o : 1'b1) & ~p_sda_oe;
    sbi_ctrl sbi_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .serial_bus_interrupt(irq));
    sbi_peer sbi_peer_i (.scl_oe(p_scl_oe), .sda_oe(p_sda_oe));
    task automatic tally_and_finish();
        if (n_mismatch == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task automatic chkw(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one idle cycle follows so a strobe is never assigned twice at an edge
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        chkw("pready", 32'h1, 32'(pready));
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp,
        input string what);
        apb(1'b0, a, 32'h0);
        chkw(what, exp, rd);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic wait_oe(input logic on_sda, input logic v);
        int n;
        n = 0;
        while ((on_sda ? sda_oe : scl_oe) !== v && n < 200) begin
            @(posedge pclk);
            n++;
        end
        chkw("line drive", 32'(v), 32'(on_sda ? sda_oe : scl_oe));
    endtask
    task automatic irq_chk(input logic exp);
        settle(2);
        chkw("interrupt", 32'(exp), 32'(irq));
    endtask
    task automatic bit_chk(input int b, input logic exp, input string what);
        apb(1'b0, 12'h000, 32'h0);
        chkw(what, 32'(exp), 32'(rd[b]));
    endtask
    initial begin
        settle(6);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(12'h000, 32'h10, "status reset");
        rchk(12'h008, 32'h0, "mask reset");
        rchk(12'h00c, 32'h0, "gear reset");
        apb(1'b0, 12'h010, 32'h0);
        chkw("unmapped err", 32'h1, 32'(err));
        chkw("unmapped data", 32'h0, rd);
        wr(12'h000, 32'hffffffc0);
        rchk(12'h000, 32'hd0, "status upper");
        for (int m = 0; m < 4; m++) begin
            wr(12'h000, 32'h0);
            wr(12'h000, 32'(m << 2));
            wr(12'h004, 32'hf);
            wr(12'h000, 32'(8'ha0 | (m << 2)));
            settle(40);
            chkw("start drive", 32'(m == 2), 32'(sda_oe));
            wr(12'h000, 32'(8'h80 | (m << 2)));
            settle(40);
            rchk(12'h004, (m == 2) ? 32'h6 : 32'h0, "events");
        end
        wr(12'h000, 32'h08);
        for (int g = 0; g < 4; g++) begin
            wr(12'h00c, 32'(g));
            wr(12'h000, 32'ha8);
            wait_oe(1'b0, 1'b1);
            t0 = cycles;
            wr(12'h000, 32'h88);
            wait_oe(1'b1, 1'b0);
            span = cycles - t0;
            chkw("tick step", 0, 32'(span % (4 << g)));
            chkw("tick bound", 1, 32'(span <= (4 << g) + 8));
            wr(12'h004, 32'hf);
        end
        wr(12'h00c, 32'h0);
        wr(12'h000, 32'h08);
        wr(12'h008, 32'h2);
        sbi_peer_i.start_cond();
        settle(8);
        irq_chk(1'b1);
        wr(12'h008, 32'h0);
        irq_chk(1'b0);
        wr(12'h008, 32'h2);
        irq_chk(1'b1);
        wr(12'h004, 32'h2);
        irq_chk(1'b0);
        for (int i = 0; i < 9; i++) begin
            sbi_peer_i.clock_bit(1'b1);
        end
        settle(8);
        bit_chk(4, 1'b0, "pending set");
        wr(12'h000, 32'h08);
        bit_chk(4, 1'b0, "pending kept");
        wr(12'h000, 32'h18);
        bit_chk(4, 1'b1, "pending clear");
        bit_chk(5, 1'b1, "busy");
        wr(12'h000, 32'ha8);
        bit_chk(3, 1'b1, "start refused");
        wr(12'h000, 32'h0a);
        wr(12'h000, 32'h08);
        wr(12'h000, 32'h09);
        bit_chk(5, 1'b1, "busy disarmed");
        wr(12'h000, 32'h0a);
        wr(12'h000, 32'h09);
        bit_chk(5, 1'b0, "busy soft reset");
        bit_chk(3, 1'b0, "lost cleared");
        sbi_peer_i.stop_cond();
        settle(8);
        wr(12'h000, 32'h0);
        wr(12'h000, 32'h04);
        wr(12'h004, 32'hf);
        for (int i = 7; i >= 0; i--) begin
            sbi_peer_i.clock_bit(1'(8'ha5 >> i));
        end
        settle(8);
        rchk(12'h004, 32'h1, "unit done");
        bit_chk(0, 1'b1, "last bit");
        wr(12'h000, 32'h0);
        tally_and_finish();
    end
endmodule
